// File: core/conv_out_end.sv
`timescale 1ns/1ns
`default_nettype none
module conv_out_end #(
	parameter int NUM_CH = adc_link_pkg::NUM_CH, // channel count
	parameter int WORD_BITS = adc_link_pkg::WORD_BITS // bits per word
) (
	adc_link_if.device link, // serial output link
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic [NUM_CH-1:0][WORD_BITS-1:0] sample_in, // stand-in for analog inputs
	output logic locked_q, // bit timing locked to sample clock
	output logic range_mismatch_q, // range selects disagree with measured rate
	output logic ref_enable_q, // internal reference powered
	output logic ref_settled_q, // reference has had its settling time
	output logic level_slvs_q, // output drivers at slvs levels
	output logic term_on_q // internal double termination on
);
	import adc_link_pkg::*;
	localparam int CTRL_W = 1 + RANGE_W + 5 + NUM_CH;

	logic [CTRL_W-1:0] ctl_s1_q;
	logic [CTRL_W-1:0] ctl_s2_q;
	logic s_clk;
	logic [RANGE_W-1:0] s_range;
	logic s_format;
	logic s_test;
	logic s_level;
	logic s_term;
	logic s_gpd;
	logic [NUM_CH-1:0] s_chpd;
	logic sclk_prev_q;
	logic sample_edge;

	// pins arrive from another party; every one but factory_test_tie passes two flops first
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctl_s1_q <= '0;
			ctl_s2_q <= '0;
		end else begin
			ctl_s1_q <= {link.sample_clk, link.mult_range_sel, link.format_sel,
				link.test_pattern_enable, link.output_level_select, link.double_term_enable,
				link.global_powerdown, link.channel_powerdown};
			ctl_s2_q <= ctl_s1_q;
		end
	end

	assign {s_clk, s_range, s_format, s_test, s_level, s_term, s_gpd, s_chpd} = ctl_s2_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= s_clk;
		end
	end

	assign sample_edge = s_clk & ~sclk_prev_q; // R4

	// measure the sample period so the slot timer can split it in twelve
	logic [PERIOD_W-1:0] cnt_q;
	logic [PERIOD_W-1:0] period_q;
	logic [1:0] edges_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
			period_q <= '0;
		end else if (sample_edge) begin
			cnt_q <= '0;
			period_q <= cnt_q + 1'b1;
		end else if (cnt_q != '1) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			edges_q <= '0;
			locked_q <= 1'b0;
		end else begin
			if (sample_edge && edges_q != 2'h2) begin
				edges_q <= edges_q + 2'h1;
			end
			// lock only at a sample edge: a mid-period start sends a short first frame
			if (sample_edge) begin
				locked_q <= (edges_q == 2'h2) && (period_q >= PERIOD_W'(SLOTS_PER_WORD));
			end
		end
	end

	// fractional accumulator: twelve slots per measured period, resynced at each edge
	logic [PERIOD_W+3:0] acc_q;
	logic [PERIOD_W+3:0] acc_sum;
	logic step;
	logic adv;
	logic [3:0] slot_q;
	logic [3:0] nslot;
	logic [3:0] wslot;

	assign acc_sum = acc_q + (PERIOD_W+4)'(SLOTS_PER_WORD);
	assign step = locked_q && !sample_edge && (acc_sum >= {4'h0, period_q});
	assign adv = locked_q && (sample_edge || step);

	always_comb begin
		if (sample_edge) begin
			nslot = 4'h0;
		end else if (slot_q == 4'(SLOTS_PER_WORD - 1)) begin
			nslot = 4'h0;
		end else begin
			nslot = slot_q + 4'h1;
		end
		if (nslot >= 4'(WORD_START_SLOT)) begin
			wslot = nslot - 4'(WORD_START_SLOT);
		end else begin
			wslot = nslot + 4'(SLOTS_PER_WORD - WORD_START_SLOT);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || sample_edge) begin
			acc_q <= '0;
		end else if (step) begin
			acc_q <= acc_sum - {4'h0, period_q};
		end else if (locked_q) begin
			acc_q <= acc_sum;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			slot_q <= '0;
		end else if (adv) begin
			slot_q <= nslot; // R1
		end
	end

	// words start half a sample period after the edge, giving the half cycle of latency
	logic load;
	logic shift;
	assign load = adv && (nslot == 4'(WORD_START_SLOT)); // R4
	assign shift = adv && !load;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			link.bit_clock_out_p <= 1'b0;
			link.bit_clock_out_n <= 1'b1;
		end else if (!locked_q) begin
			link.bit_clock_out_p <= 1'b0;
			link.bit_clock_out_n <= 1'b1;
		end else if (adv) begin
			link.bit_clock_out_p <= ~wslot[0]; // R1 R5
			link.bit_clock_out_n <= wslot[0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			link.frame_marker_p <= 1'b0;
			link.frame_marker_n <= 1'b1;
		end else if (!locked_q) begin
			link.frame_marker_p <= 1'b0;
			link.frame_marker_n <= 1'b1;
		end else if (adv) begin
			link.frame_marker_p <= wslot < 4'(FRAME_HIGH_SLOTS); // R7 R8 R17
			link.frame_marker_n <= wslot >= 4'(FRAME_HIGH_SLOTS);
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			ch_serializer #(
				.WORD_BITS(WORD_BITS),
				.DEPTH(LAT_WORDS + 1)
			) u_ser (
				.clk(clk),
				.rst_n(rst_n),
				.sample_edge(sample_edge && locked_q),
				.load(load),
				.shift(shift),
				.sample(sample_in[g]),
				.offset_bin(s_format),
				.test_en(s_test),
				.pd(s_chpd[g] | s_gpd),
				.bit_p_q(link.data_out_p[g]),
				.bit_n_q(link.data_out_n[g])
			);
		end
	endgenerate

	// reference follows the global power-down; settling only reported, not enforced
	logic [$clog2(REF_SETTLE_CYCLES+1)-1:0] settle_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ref_enable_q <= 1'b0;
		end else begin
			ref_enable_q <= ~s_gpd; // R13
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !ref_enable_q) begin
			settle_q <= '0;
			ref_settled_q <= 1'b0;
		end else if (settle_q != ($bits(settle_q))'(REF_SETTLE_CYCLES)) begin
			settle_q <= settle_q + 1'b1;
			ref_settled_q <= 1'b0;
		end else begin
			ref_settled_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			level_slvs_q <= 1'b0;
			link.level_is_slvs <= 1'b0;
			term_on_q <= 1'b0;
		end else begin
			level_slvs_q <= s_level; // R11
			link.level_is_slvs <= s_level;
			term_on_q <= s_term;
		end
	end

	// flags a host whose range selects do not fit the rate it actually runs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			range_mismatch_q <= 1'b0;
		end else if (locked_q) begin
			range_mismatch_q <= range_code_for(period_q) != s_range;
		end else begin
			range_mismatch_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: core/adc_link_pkg.sv
// Notes on behaviour
// [R1] bit clock runs six times sample clock
// [R2] host sets range selects matching sample rate
// [R3] host ties factory test select low
// [R4] sample on rising edge, output 6.5 cycles later
// [R5] one data bit per bit-clock half period
// [R6] each 12-bit word goes out LSB first
// [R7] frame marker rises with first word bit
// [R8] frame marker runs at sample rate
// [R9] format low two's complement, high offset binary
// [R10] offset binary equals two's complement plus 2048
// [R11] level select picks LVDS or SLVS levels
// [R12] host enables double termination with SLVS
// [R13] global power-down disables the reference
// [R14] host discards data 132 us after power-up
// [R15] test enable sends fixed pattern, LSB first
// [R16] channel power-down input silences its channel
// [R17] frame high six bit times, low six
package adc_link_pkg;
	localparam int NUM_CH = 4;
	localparam int WORD_BITS = 12;
	localparam int BIT_CLK_MULT = 6;
	localparam int SLOTS_PER_WORD = 2 * BIT_CLK_MULT;
	localparam int FRAME_HIGH_SLOTS = 6;
	localparam int WORD_START_SLOT = 6;
	localparam int LAT_WORDS = 6;
	localparam int PERIOD_W = 16;
	localparam int RANGE_W = 3;
	localparam logic [WORD_BITS-1:0] OFFSET_FLIP = 12'h800;
	localparam logic [WORD_BITS-1:0] TEST_PATTERN = 12'h0BD;
	localparam int CLK_PERIOD_NS = 100;
	localparam int CLK_KHZ = 10000;
	localparam int REF_SETTLE_US = 132;
	localparam int REF_SETTLE_CYCLES = (REF_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RANGE_MIN_KHZ [0:7] = '{45000, 32500, 22500, 16300, 11300, 8100, 5600, 4000};

	// lowest-numbered band whose floor the rate still meets; slower rates fall to the last band
	function automatic logic [RANGE_W-1:0] range_code_for(input logic [PERIOD_W-1:0] period_cyc);
		logic [RANGE_W-1:0] code;
		code = 3'h7;
		for (int i = 6; i >= 0; i--) begin
			if (64'(period_cyc) * 64'(RANGE_MIN_KHZ[i]) <= 64'(CLK_KHZ)) begin
				code = 3'(i);
			end
		end
		return code;
	endfunction
endpackage

// File: core/adc_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface adc_link_if;
	import adc_link_pkg::*;
	logic sample_clk;
	logic [RANGE_W-1:0] mult_range_sel;
	logic factory_test_tie;
	logic format_sel;
	logic output_level_select;
	logic double_term_enable;
	logic global_powerdown;
	logic [NUM_CH-1:0] channel_powerdown;
	logic test_pattern_enable;
	logic bit_clock_out_p;
	logic bit_clock_out_n;
	logic frame_marker_p;
	logic frame_marker_n;
	logic [NUM_CH-1:0] data_out_p;
	logic [NUM_CH-1:0] data_out_n;
	logic level_is_slvs;

	modport device (
		input sample_clk, mult_range_sel, factory_test_tie, format_sel, output_level_select,
		input double_term_enable, global_powerdown, channel_powerdown, test_pattern_enable,
		output bit_clock_out_p, bit_clock_out_n, frame_marker_p, frame_marker_n,
		output data_out_p, data_out_n, level_is_slvs
	);
	modport host (
		output sample_clk, mult_range_sel, factory_test_tie, format_sel, output_level_select,
		output double_term_enable, global_powerdown, channel_powerdown, test_pattern_enable,
		input bit_clock_out_p, bit_clock_out_n, frame_marker_p, frame_marker_n,
		input data_out_p, data_out_n, level_is_slvs
	);
endinterface
`default_nettype wire

// File: core/ch_serializer.sv
`timescale 1ns/1ns
`default_nettype none
module ch_serializer #(
	parameter int WORD_BITS = adc_link_pkg::WORD_BITS, // bits per word
	parameter int DEPTH = adc_link_pkg::LAT_WORDS + 1 // words held in flight
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic sample_edge, // one-cycle pulse at sample clock rise
	input wire logic load, // one-cycle pulse at word start
	input wire logic shift, // one-cycle pulse at other bit slots
	input wire logic [WORD_BITS-1:0] sample, // converted two's complement sample
	input wire logic offset_bin, // offset binary format selected
	input wire logic test_en, // fixed pattern in place of data
	input wire logic pd, // channel silenced
	output logic bit_p_q, // serial bit, true side
	output logic bit_n_q // serial bit, complement side
);
	import adc_link_pkg::*;
	logic [WORD_BITS-1:0] pipe_q [0:DEPTH-1];
	logic [WORD_BITS-1:0] sreg_q;
	logic [WORD_BITS-1:0] word;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				pipe_q[i] <= '0;
			end
		end else if (sample_edge) begin
			pipe_q[0] <= sample; // R4
			for (int i = 1; i < DEPTH; i++) begin
				pipe_q[i] <= pipe_q[i-1];
			end
		end
	end

	always_comb begin
		if (pd) begin
			word = '0; // R16
		end else if (test_en) begin
			word = TEST_PATTERN; // R15
		end else if (offset_bin) begin
			word = pipe_q[DEPTH-1] ^ OFFSET_FLIP; // R9 R10
		end else begin
			word = pipe_q[DEPTH-1]; // R9
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sreg_q <= '0;
			bit_p_q <= 1'b0;
			bit_n_q <= 1'b1;
		end else if (load) begin
			sreg_q <= word >> 1;
			bit_p_q <= word[0]; // R6
			bit_n_q <= ~word[0];
		end else if (shift) begin
			sreg_q <= sreg_q >> 1; // R6
			bit_p_q <= sreg_q[0]; // R5
			bit_n_q <= ~sreg_q[0];
		end
	end
endmodule
`default_nettype wire

// File: core/conv_rx_end.sv
`timescale 1ns/1ns
`default_nettype none
module conv_rx_end #(
	parameter int NUM_CH = adc_link_pkg::NUM_CH, // channel count
	parameter int WORD_BITS = adc_link_pkg::WORD_BITS, // bits per word
	parameter int SAMPLE_DIV = 48, // system clocks per sample clock, even
	parameter int SETTLE_CYCLES = adc_link_pkg::REF_SETTLE_CYCLES // reference settle wait
) (
	adc_link_if.host link, // serial input link
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic offset_bin, // request offset binary codes
	input wire logic test_en, // request test pattern
	input wire logic slvs_sel, // request slvs levels
	input wire logic gpd, // global power-down request
	input wire logic [NUM_CH-1:0] ch_pd, // per-channel power-down request
	output logic [NUM_CH-1:0][WORD_BITS-1:0] words_q, // last received words
	output logic word_valid_q, // one-cycle pulse: new words
	output logic aligned_q, // frame marker has been found
	output logic conv_valid_q // reference settled, data trustworthy
);
	import adc_link_pkg::*;
	localparam int HALF_DIV = SAMPLE_DIV / 2;
	localparam int RX_W = 2 + NUM_CH;

	logic [$clog2(HALF_DIV)-1:0] div_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_q <= '0;
			link.sample_clk <= 1'b0;
		end else if (div_q == ($bits(div_q))'(HALF_DIV - 1)) begin
			div_q <= '0;
			link.sample_clk <= ~link.sample_clk;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			link.mult_range_sel <= 3'h7;
			link.factory_test_tie <= 1'b0;
			link.format_sel <= 1'b0;
			link.output_level_select <= 1'b0;
			link.double_term_enable <= 1'b0;
			link.global_powerdown <= 1'b0;
			link.channel_powerdown <= '0;
			link.test_pattern_enable <= 1'b0;
		end else begin
			link.mult_range_sel <= range_code_for(PERIOD_W'(SAMPLE_DIV)); // R2
			link.factory_test_tie <= 1'b0; // R3
			link.format_sel <= offset_bin;
			link.output_level_select <= slvs_sel;
			link.double_term_enable <= slvs_sel; // R12
			link.global_powerdown <= gpd;
			link.channel_powerdown <= ch_pd;
			link.test_pattern_enable <= test_en;
		end
	end

	// only the true side of each pair is sampled
	logic [RX_W-1:0] rx_s1_q;
	logic [RX_W-1:0] rx_s2_q;
	logic ck_prev_q;
	logic fr_prev_q;
	logic bedge;
	logic [NUM_CH-1:0][WORD_BITS-1:0] asm_q;
	logic [3:0] bits_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_s1_q <= '0;
			rx_s2_q <= '0;
			ck_prev_q <= 1'b0;
			fr_prev_q <= 1'b0;
		end else begin
			rx_s1_q <= {link.bit_clock_out_p, link.frame_marker_p, link.data_out_p};
			rx_s2_q <= rx_s1_q;
			ck_prev_q <= rx_s2_q[RX_W-1];
			fr_prev_q <= rx_s2_q[RX_W-2];
		end
	end

	assign bedge = rx_s2_q[RX_W-1] ^ ck_prev_q; // R5

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			asm_q <= '0;
			bits_q <= '0;
			aligned_q <= 1'b0;
			word_valid_q <= 1'b0;
			words_q <= '0;
		end else begin
			word_valid_q <= 1'b0;
			if (bedge) begin
				for (int c = 0; c < NUM_CH; c++) begin
					asm_q[c] <= {rx_s2_q[c], asm_q[c][WORD_BITS-1:1]}; // R6
				end
				if (rx_s2_q[RX_W-2] && !fr_prev_q) begin
					bits_q <= 4'h1; // R7
					aligned_q <= 1'b1;
				end else if (bits_q == 4'(WORD_BITS - 1)) begin
					bits_q <= '0;
					word_valid_q <= aligned_q;
					for (int c = 0; c < NUM_CH; c++) begin
						words_q[c] <= {rx_s2_q[c], asm_q[c][WORD_BITS-1:1]};
					end
				end else begin
					bits_q <= bits_q + 4'h1;
				end
			end
		end
	end

	logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_q;

	always_ff @(posedge clk) begin
		if (!rst_n || gpd) begin
			settle_q <= '0;
			conv_valid_q <= 1'b0;
		end else if (settle_q != ($bits(settle_q))'(SETTLE_CYCLES)) begin
			settle_q <= settle_q + 1'b1; // R14
			conv_valid_q <= 1'b0;
		end else begin
			conv_valid_q <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: sim/adc_link_chk.sv
`timescale 1ns/1ns
`default_nettype none
module adc_link_chk
	import adc_link_pkg::*;
#(
	parameter int SAMPLE_DIV = 48 // clocks per sample period
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // sync reset, low
	input wire logic bit_clock_out_p, // bit clock
	input wire logic bit_clock_out_n, // bit clock, inverse
	input wire logic frame_marker_p, // frame
	input wire logic frame_marker_n, // frame, inverse
	input wire logic [NUM_CH-1:0] data_out_p, // data
	input wire logic [NUM_CH-1:0] data_out_n, // data, inverse
	input wire logic [RANGE_W-1:0] mult_range_sel, // band code
	input wire logic factory_test_tie, // test select
	input wire logic output_level_select, // level request
	input wire logic double_term_enable, // termination
	input wire logic level_is_slvs, // level status
	input wire logic global_powerdown, // all down
	input wire logic test_pattern_enable // fixed pattern
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic seen_q, fr_prev_q, bc_prev_q;
	logic [15:0] fr_cnt_q, bc_cnt_q;
	logic [7:0] pd_cnt_q;

	// the frame count restarts at each frame rise; the duty, rate and bit-slot checks wait for the first frame rise
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			seen_q <= 1'b0;
			fr_prev_q <= 1'b0;
			fr_cnt_q <= 16'h0000;
		end else begin
			fr_prev_q <= frame_marker_p;
			fr_cnt_q <= (frame_marker_p && !fr_prev_q) ? 16'h0001 : fr_cnt_q + 16'h0001;
			seen_q <= seen_q | (frame_marker_p && !fr_prev_q);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bc_prev_q <= 1'b0;
			bc_cnt_q <= 16'h0000;
		end else begin
			bc_prev_q <= bit_clock_out_p;
			bc_cnt_q <= (bit_clock_out_p != bc_prev_q) ? 16'h0001 : bc_cnt_q + 16'h0001;
		end
	end

	// saturates; controls only bite at the next word load
	always_ff @(posedge clk) begin
		if (!rst_n || !global_powerdown) begin
			pd_cnt_q <= 8'h00;
		end else if (pd_cnt_q != 8'hFF) begin
			pd_cnt_q <= pd_cnt_q + 8'h01;
		end
	end

	clk_pair_a: assert property (bit_clock_out_n == ~bit_clock_out_p)
		else $error("bit clock pair not complementary");
	frame_pair_a: assert property (frame_marker_n == ~frame_marker_p)
		else $error("frame pair not complementary");
	data_pair_a: assert property (data_out_n == ~data_out_p)
		else $error("data pair not complementary");
	frame_first_bit_a: assert property ($rose(frame_marker_p) |-> $rose(bit_clock_out_p))
		else $error("frame rise not on first bit");
	frame_duty_a: assert property ($fell(frame_marker_p) && seen_q |-> fr_cnt_q == 16'(SAMPLE_DIV / 2))
		else $error("frame high time wrong");
	frame_rate_a: assert property ($rose(frame_marker_p) && seen_q |-> fr_cnt_q == 16'(SAMPLE_DIV))
		else $error("frame period differs from sample period");
	bit_slot_a: assert property ($changed(bit_clock_out_p) && seen_q |-> bc_cnt_q == 16'(SAMPLE_DIV / 12))
		else $error("bit clock half period wrong");
	data_on_edge_a: assert property ($changed(data_out_p) |-> $changed(bit_clock_out_p))
		else $error("data moved off a bit clock edge");
	level_follow_a: assert property ($rose(output_level_select) |-> ##[1:4] level_is_slvs)
		else $error("level select not taken");
	term_match_a: assert property (double_term_enable == output_level_select)
		else $error("termination differs from level select");
	test_tie_low_a: assert property (factory_test_tie == 1'b0)
		else $error("factory test select high");
	range_code_a: assert property (mult_range_sel == 3'h7)
		else $error("band code wrong for slow sample clock");
	pd_silence_a: assert property (pd_cnt_q > 8'h64 |-> data_out_p == '0)
		else $error("data sent while powered down");

	cover property ($rose(frame_marker_p) && test_pattern_enable);
	cover property ($rose(global_powerdown));
	cover property ($rose(output_level_select));
endmodule
`default_nettype wire

// File: sim/test_adc_serial_lvds_output.sv
`timescale 1ns/1ns
`default_nettype none
module test_adc_serial_lvds_output;
	import adc_link_pkg::*;
	localparam int SAMPLE_DIV = 48;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [NUM_CH-1:0][WORD_BITS-1:0] sample_in = {12'hFFF, 12'h000, 12'h800, 12'h7FF};
	logic offset_bin = 1'b0;
	logic test_en = 1'b0;
	logic slvs_sel = 1'b0;
	logic gpd = 1'b0;
	logic [NUM_CH-1:0] ch_pd = 4'h0;
	logic [NUM_CH-1:0][WORD_BITS-1:0] words;
	logic word_valid, aligned, conv_valid, locked, mismatch, ref_en, ref_ok, slvs_st, term_st;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	int lat;
	int case_no = 0;
	logic bc_prev, fr_prev;
	logic [3:0] idx = 4'h0;
	logic [11:0] sh, mon_word;

	adc_link_if u_adc_link_if();
	conv_out_end u_conv_out_end (.link(u_adc_link_if), .clk(clk), .rst_n(rst_n),
		.sample_in(sample_in), .locked_q(locked), .range_mismatch_q(mismatch),
		.ref_enable_q(ref_en), .ref_settled_q(ref_ok), .level_slvs_q(slvs_st),
		.term_on_q(term_st));
	conv_rx_end #(.SAMPLE_DIV(SAMPLE_DIV), .SETTLE_CYCLES(20)) u_conv_rx_end (
		.link(u_adc_link_if), .clk(clk), .rst_n(rst_n), .offset_bin(offset_bin),
		.test_en(test_en), .slvs_sel(slvs_sel), .gpd(gpd), .ch_pd(ch_pd), .words_q(words),
		.word_valid_q(word_valid), .aligned_q(aligned), .conv_valid_q(conv_valid));
	adc_link_chk #(.SAMPLE_DIV(SAMPLE_DIV)) u_adc_link_chk (.clk(clk), .rst_n(rst_n),
		.bit_clock_out_p(u_adc_link_if.bit_clock_out_p),
		.bit_clock_out_n(u_adc_link_if.bit_clock_out_n),
		.frame_marker_p(u_adc_link_if.frame_marker_p),
		.frame_marker_n(u_adc_link_if.frame_marker_n),
		.data_out_p(u_adc_link_if.data_out_p), .data_out_n(u_adc_link_if.data_out_n),
		.mult_range_sel(u_adc_link_if.mult_range_sel),
		.factory_test_tie(u_adc_link_if.factory_test_tie),
		.output_level_select(u_adc_link_if.output_level_select),
		.double_term_enable(u_adc_link_if.double_term_enable),
		.level_is_slvs(u_adc_link_if.level_is_slvs),
		.global_powerdown(u_adc_link_if.global_powerdown),
		.test_pattern_enable(u_adc_link_if.test_pattern_enable));

	always #50 clk = ~clk;

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			$display("CHECK FAILED run length expected 20000 seen more");
			complete_run();
		end
	end

	// rebuilds channel 0 straight off the wire, independent of the receiver
	always @(posedge clk) begin
		if (u_adc_link_if.bit_clock_out_p !== bc_prev) begin
			if (u_adc_link_if.frame_marker_p && !fr_prev) begin
				idx = 4'h0;
			end
			sh[idx] = u_adc_link_if.data_out_p[0];
			if (idx == 4'hB) begin
				mon_word = sh;
			end
			idx = idx + 4'h1;
		end
		bc_prev = u_adc_link_if.bit_clock_out_p;
		fr_prev = u_adc_link_if.frame_marker_p;
	end

	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wait_words(input int n);
		repeat (n) begin
			do @(negedge clk); while (word_valid !== 1'b1);
		end
	endtask

	function automatic logic [11:0] exp_word(input int k);
		if (gpd || ch_pd[k]) return 12'h000;
		if (test_en) return 12'h0BD;
		return offset_bin ? sample_in[k] + 12'h800 : sample_in[k];
	endfunction

	// 11 words flushes the pipeline and any control change
	task automatic run_case(input logic ob, input logic te, input logic sl, input logic g,
			input logic [3:0] pd);
		@(negedge clk);
		offset_bin = ob;
		test_en = te;
		slvs_sel = sl;
		gpd = g;
		ch_pd = pd;
		wait_words(11);
		for (int k = 0; k < NUM_CH; k++) begin
			check("channel word", words[k], exp_word(k));
		end
		check("wire word", mon_word, exp_word(0));
		check("slvs level", 12'(slvs_st), 12'(sl));
		check("termination", 12'(term_st), 12'(sl));
		check("lock", 12'({locked, aligned, mismatch}), 12'h006);
		case_no++;
		$display("case %0d done", case_no);
	endtask

	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		run_case(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
		run_case(1'b1, 1'b0, 1'b1, 1'b0, 4'h0);
		run_case(1'b1, 1'b1, 1'b0, 1'b0, 4'h0);
		run_case(1'b0, 1'b0, 1'b1, 1'b0, 4'h5);
		run_case(1'b0, 1'b0, 1'b0, 1'b1, 4'h0);
		check("reference off", 12'({ref_en, conv_valid}), 12'h000);
		@(negedge clk);
		gpd = 1'b0;
		repeat (100) @(negedge clk);
		check("reference settling", 12'({ref_en, ref_ok, conv_valid}), 12'h005);
		wait_words(30);
		check("reference settled", 12'({ref_ok, conv_valid}), 12'h003);
		$display("power-down case done");
		// new value lands just after the sample clock rise, ahead of the synced sample edge
		@(posedge u_adc_link_if.sample_clk);
		@(negedge clk);
		sample_in[0] = 12'h5A3;
		lat = cyc;
		while (mon_word !== 12'h5A3) @(negedge clk);
		lat = cyc - lat;
		check("sample latency", 12'(lat >= 356 && lat <= 368), 12'h001);
		wait_words(1);
		check("latency word", words[0], 12'h5A3);
		$display("latency case done");
		complete_run();
	end
endmodule
`default_nettype wire
